/* File: design/i2c_host_pkg.sv */
// Constants and types shared by the two-wire host controller
package i2c_host_pkg;

  // Bus timing derived from the system clock
  localparam int unsigned SYS_CLK_HZ    = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SCL_STD_HZ    = 100_000;
  localparam int unsigned SCL_FAST_HZ   = 400_000;
  // A quarter bit period is a least time, so it rounds up
  localparam int unsigned QTR_STD_CYC   =
    (SYS_CLK_HZ + 4 * SCL_STD_HZ - 1) / (4 * SCL_STD_HZ);
  localparam int unsigned QTR_FAST_CYC  =
    (SYS_CLK_HZ + 4 * SCL_FAST_HZ - 1) / (4 * SCL_FAST_HZ);
  localparam logic [7:0]  QTR_STD       = 8'(QTR_STD_CYC);
  localparam logic [7:0]  QTR_FAST      = 8'(QTR_FAST_CYC);

  // Input spikes shorter than this are suppressed
  localparam int unsigned GLITCH_NS     = 50;
  localparam int unsigned GLITCH_CYC    =
    (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Slave address layout, direction codes and ack bit index
  localparam logic [3:0]  SLAVE_ADDR_HI = 4'h9;
  localparam logic        RW_WRITE      = 1'b0;
  localparam logic        RW_READ       = 1'b1;
  localparam logic [3:0]  ACK_BIT_IDX   = 4'h8;

  // Reset values
  localparam logic [7:0]  BYTE_RST      = 8'h00;
  localparam logic [15:0] COUNT_RST     = 16'h0000;
  localparam logic [7:0]  TMR_RST       = 8'h00;
  localparam logic        LINE_IDLE     = 1'b1;

  typedef struct packed {
    logic        rnw;
    logic [2:0]  strap;
    logic [15:0] reg_addr;
    logic [15:0] count;
  } xfer_req_t;

  typedef enum {
    ST_IDLE,
    ST_START,
    ST_BIT,
    ST_WAIT,
    ST_STOP
  } ctrl_state_t;

  typedef enum {
    PH_SADDR_W,
    PH_ADDR_HI,
    PH_ADDR_LO,
    PH_WDATA,
    PH_SADDR_R,
    PH_RDATA
  } byte_phase_t;

endpackage : i2c_host_pkg

/* File: design/line_filter.sv */
// Two-flop synchroniser plus spike suppressor for one bus line
`timescale 1ns/1ps
module line_filter
  import i2c_host_pkg::*;
#(
  parameter int unsigned FILT_CYC = GLITCH_CYC
) (
  input  wire logic i_sys_clk,
  input  wire logic i_srst,
  input  wire logic i_line,
  output logic      o_level
);

  logic       meta_ff;
  logic       sync_ff;
  logic       level_ff;
  logic [7:0] cnt_ff;

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      meta_ff <= LINE_IDLE;
      sync_ff <= LINE_IDLE;
    end else begin
      meta_ff <= i_line;
      sync_ff <= meta_ff;
    end
  end

  // A new level must persist for the whole window before it is taken
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      level_ff <= LINE_IDLE;
      cnt_ff   <= TMR_RST;
    end else if (sync_ff == level_ff) begin
      cnt_ff <= TMR_RST;
    end else if (cnt_ff == 8'(FILT_CYC - 1)) begin
      level_ff <= sync_ff;
      cnt_ff   <= TMR_RST;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  assign o_level = level_ff;

endmodule : line_filter

/* File: design/i2c_host_ctrl.sv */
// Two-wire bus master that reads and writes the device's registers
`timescale 1ns/1ps
// Notes on behaviour
// - Data changes only while clock is low; stable while high.
// - Data falling while clock high marks a start.
// - Data rising while clock high marks a stop.
// - Each byte is eight bits, MSB first, then one ack bit.
// - Receiver acknowledges by pulling data low on ninth pulse.
// - Receiver refuses by leaving data high on ninth pulse.
// - First byte is 7-bit address then direction, 0 write 1 read.
// - Write sends 16-bit register address, upper byte first.
// - Read is address write, repeated start, read address, data.
// - Master refuses the last read byte; device then goes idle.
// - After the last write byte is acknowledged the master stops.
module i2c_host_ctrl
  import i2c_host_pkg::*;
#(
  parameter int unsigned FILT_CYC = GLITCH_CYC
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_srst,
  input  wire logic       i_req_valid,
  input  wire xfer_req_t  i_req,
  input  wire logic       i_fast_mode,
  input  wire logic       i_wr_valid,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_scl_in,
  input  wire logic       i_sda_in,
  output logic            o_scl_out,
  output logic            o_scl_oe,
  output logic            o_sda_out,
  output logic            o_sda_oe,
  output logic            o_req_ready,
  output logic            o_done,
  output logic            o_nack,
  output logic            o_wr_pop,
  output logic            o_rd_valid,
  output logic [7:0]      o_rd_data
);

  ctrl_state_t state_ff;
  byte_phase_t phase_ff;
  xfer_req_t   req_ff;
  logic [1:0]  q_ff;
  logic [3:0]  bit_ff;
  logic [7:0]  tx_ff;
  logic [7:0]  rx_ff;
  logic [7:0]  tmr_ff;
  logic [15:0] remain_ff;
  logic        scl_oe_ff;
  logic        sda_oe_ff;
  logic        pull_ff;
  logic        ack_ff;
  logic        nack_ff;
  logic        done_ff;
  logic        ready_ff;
  logic        pop_ff;
  logic        rd_valid_ff;
  logic [7:0]  rd_data_ff;

  logic        scl_f;
  logic        sda_f;
  logic        hold_clk;
  logic        qend;
  logic        byte_end;
  logic        rd_phase;
  logic [3:0]  bit_pos;

  line_filter #(
    .FILT_CYC (FILT_CYC)
  ) u_scl_filt (
    .i_sys_clk (i_sys_clk),
    .i_srst    (i_srst),
    .i_line    (i_scl_in),
    .o_level   (scl_f)
  );

  line_filter #(
    .FILT_CYC (FILT_CYC)
  ) u_sda_filt (
    .i_sys_clk (i_sys_clk),
    .i_srst    (i_srst),
    .i_line    (i_sda_in),
    .o_level   (sda_f)
  );

  // A released clock is not timed until it is seen high on the wire
  assign hold_clk = !scl_oe_ff && !scl_f;
  assign qend     = (tmr_ff == TMR_RST) && !hold_clk &&
                    (state_ff inside {ST_START, ST_BIT, ST_STOP});
  assign byte_end = qend && (state_ff == ST_BIT) && (q_ff == 2'd3) &&
                    (bit_ff == ACK_BIT_IDX);
  assign rd_phase = (phase_ff == PH_RDATA);
  assign bit_pos  = 4'd7 - bit_ff;

  // Quarter-bit timer; reloaded while idle or stalled for data
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      tmr_ff <= TMR_RST;
    end else if (state_ff == ST_IDLE) begin
      tmr_ff <= (i_fast_mode ? QTR_FAST : QTR_STD) - 8'h01;
    end else if (state_ff == ST_WAIT || qend) begin
      tmr_ff <= i_fast_mode ?
                QTR_FAST - 8'h01 : QTR_STD - 8'h01;
    end else if (!hold_clk && tmr_ff != TMR_RST) begin
      tmr_ff <= tmr_ff - 8'h01;
    end
  end

  // Read data shifts in MSB first, sampled mid clock-high
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      rx_ff <= BYTE_RST;
    end else if (qend && state_ff == ST_BIT && q_ff == 2'd2 &&
                 bit_ff != ACK_BIT_IDX) begin
      rx_ff <= {rx_ff[6:0], sda_f};
    end
  end

  // Pins are open drain: the level driven is always low
  always_ff @(posedge i_sys_clk) begin
    pull_ff <= 1'b0;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state_ff    <= ST_IDLE;
      phase_ff    <= PH_SADDR_W;
      req_ff      <= '0;
      q_ff        <= 2'd0;
      bit_ff      <= 4'd0;
      tx_ff       <= BYTE_RST;
      remain_ff   <= COUNT_RST;
      scl_oe_ff   <= 1'b0;
      sda_oe_ff   <= 1'b0;
      ack_ff      <= 1'b0;
      nack_ff     <= 1'b0;
      done_ff     <= 1'b0;
      ready_ff    <= 1'b1;
      pop_ff      <= 1'b0;
      rd_valid_ff <= 1'b0;
      rd_data_ff  <= BYTE_RST;
    end else begin
      done_ff     <= 1'b0;
      pop_ff      <= 1'b0;
      rd_valid_ff <= 1'b0;
      unique case (state_ff)
        ST_IDLE: begin
          if (i_req_valid) begin
            req_ff    <= i_req;
            remain_ff <= i_req.count;
            tx_ff     <= {SLAVE_ADDR_HI, i_req.strap, RW_WRITE};
            phase_ff  <= PH_SADDR_W;
            nack_ff   <= 1'b0;
            ready_ff  <= 1'b0;
            q_ff      <= 2'd0;
            state_ff  <= ST_START;
          end
        end
        // Also serves as repeated start, entered with the clock low
        ST_START: begin
          if (qend) begin
            q_ff <= q_ff + 2'd1;
            unique case (q_ff)
              2'd0: sda_oe_ff <= 1'b0;
              2'd1: scl_oe_ff <= 1'b0;
              2'd2: sda_oe_ff <= 1'b1;
              2'd3: begin
                scl_oe_ff <= 1'b1;
                bit_ff    <= 4'd0;
                state_ff  <= ST_BIT;
              end
            endcase
          end
        end
        ST_BIT: begin
          if (qend) begin
            q_ff <= q_ff + 2'd1;
            unique case (q_ff)
              2'd0: begin
                // Data moves only in the low half of the bit
                if (bit_ff == ACK_BIT_IDX) begin
                  sda_oe_ff <= rd_phase && (remain_ff != 16'h0001);
                end else begin
                  sda_oe_ff <= !rd_phase && !tx_ff[bit_pos[2:0]];
                end
              end
              2'd1: scl_oe_ff <= 1'b0;
              2'd2: begin
                if (bit_ff == ACK_BIT_IDX) begin
                  ack_ff <= sda_f;
                end
              end
              2'd3: begin
                scl_oe_ff <= 1'b1;
                if (bit_ff != ACK_BIT_IDX) begin
                  bit_ff <= bit_ff + 4'd1;
                end else begin
                  bit_ff <= 4'd0;
                  if (!rd_phase && ack_ff) begin
                    // Refused byte: give up the transfer
                    nack_ff  <= 1'b1;
                    state_ff <= ST_STOP;
                  end else begin
                    unique case (phase_ff)
                      PH_SADDR_W: begin
                        phase_ff <= PH_ADDR_HI;
                        tx_ff    <= req_ff.reg_addr[15:8];
                      end
                      PH_ADDR_HI: begin
                        phase_ff <= PH_ADDR_LO;
                        tx_ff    <= req_ff.reg_addr[7:0];
                      end
                      PH_ADDR_LO: begin
                        if (req_ff.rnw && req_ff.count != COUNT_RST) begin
                          phase_ff <= PH_SADDR_R;
                          tx_ff    <= {SLAVE_ADDR_HI, req_ff.strap,
                                       RW_READ};
                          state_ff <= ST_START;
                        end else if (remain_ff == COUNT_RST) begin
                          state_ff <= ST_STOP;
                        end else begin
                          phase_ff <= PH_WDATA;
                          state_ff <= ST_WAIT;
                        end
                      end
                      PH_WDATA: begin
                        remain_ff <= remain_ff - 16'h0001;
                        if (remain_ff == 16'h0001) begin
                          state_ff <= ST_STOP;
                        end else begin
                          state_ff <= ST_WAIT;
                        end
                      end
                      PH_SADDR_R: begin
                        phase_ff <= PH_RDATA;
                      end
                      PH_RDATA: begin
                        rd_valid_ff <= 1'b1;
                        rd_data_ff  <= rx_ff;
                        remain_ff   <= remain_ff - 16'h0001;
                        if (remain_ff == 16'h0001) begin
                          state_ff <= ST_STOP;
                        end
                      end
                    endcase
                  end
                end
              end
            endcase
          end
        end
        // Clock is held low until the user supplies the next byte
        ST_WAIT: begin
          if (i_wr_valid) begin
            tx_ff    <= i_wr_data;
            pop_ff   <= 1'b1;
            q_ff     <= 2'd0;
            bit_ff   <= 4'd0;
            state_ff <= ST_BIT;
          end
        end
        ST_STOP: begin
          if (qend) begin
            q_ff <= q_ff + 2'd1;
            unique case (q_ff)
              2'd0: sda_oe_ff <= 1'b1;
              2'd1: scl_oe_ff <= 1'b0;
              2'd2: sda_oe_ff <= 1'b0;
              2'd3: begin
                done_ff  <= 1'b1;
                ready_ff <= 1'b1;
                state_ff <= ST_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end

  assign o_scl_out   = pull_ff;
  assign o_sda_out   = pull_ff;
  assign o_scl_oe    = scl_oe_ff;
  assign o_sda_oe    = sda_oe_ff;
  assign o_req_ready = ready_ff;
  assign o_done      = done_ff;
  assign o_nack      = nack_ff;
  assign o_wr_pop    = pop_ff;
  assign o_rd_valid  = rd_valid_ff;
  assign o_rd_data   = rd_data_ff;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);

  chk_bit_range: assert property (bit_ff <= ACK_BIT_IDX)
    else $error("bit index beyond ack position");

  chk_sda_stable_high: assert property (
    (state_ff == ST_BIT && !scl_oe_ff && !$changed(scl_oe_ff))
      |-> $stable(sda_oe_ff))
    else $error("data moved while clock released");

  chk_start_edge: assert property (
    (state_ff == ST_START && $rose(sda_oe_ff)) |-> !scl_oe_ff && scl_f)
    else $error("start edge without clock high");

  chk_stop_edge: assert property (
    (state_ff == ST_STOP && $fell(sda_oe_ff))
      |-> !scl_oe_ff ##[1:300] done_ff)
    else $error("stop edge not followed by done");

  chk_addr_pattern: assert property (
    (state_ff == ST_START && q_ff == 2'd0)
      |-> tx_ff[7:4] == SLAVE_ADDR_HI &&
          tx_ff[0] == (phase_ff == PH_SADDR_R))
    else $error("bad slave address byte");

  chk_read_ack: assert property (
    (state_ff == ST_BIT && rd_phase && bit_ff == ACK_BIT_IDX &&
     q_ff == 2'd1) |-> sda_oe_ff == (remain_ff != 16'h0001))
    else $error("wrong ack on read byte");

  chk_addr_hi_first: assert property (
    (byte_end && phase_ff == PH_SADDR_W && !ack_ff)
      |=> phase_ff == PH_ADDR_HI && tx_ff == req_ff.reg_addr[15:8])
    else $error("register address upper byte not sent first");

  chk_write_stop: assert property (
    (byte_end && phase_ff == PH_WDATA && !ack_ff &&
     remain_ff == 16'h0001) |=> state_ff == ST_STOP)
    else $error("no stop after last write byte");

  chk_read_stop: assert property (
    (byte_end && rd_phase && remain_ff == 16'h0001)
      |=> state_ff == ST_STOP && rd_valid_ff)
    else $error("no stop after refused last read byte");

  chk_repeat_start: assert property (
    (byte_end && phase_ff == PH_ADDR_LO && !ack_ff && req_ff.rnw &&
     req_ff.count != COUNT_RST)
      |=> state_ff == ST_START && phase_ff == PH_SADDR_R)
    else $error("read without repeated start");

  cov_write_done: cover property (done_ff && !nack_ff && !req_ff.rnw);
  cov_read_done: cover property (done_ff && !nack_ff && req_ff.rnw);
  cov_nack_abort: cover property (done_ff && nack_ff);
  cov_wait_stall: cover property (state_ff == ST_WAIT [*3]);

endmodule : i2c_host_ctrl

/* File: dv/i2c_dev_model.sv */
// Behavioural two-wire register device that answers the host controller
`timescale 1ns/1ps
module i2c_dev_model #(
  parameter logic [2:0] STRAP = 3'h5
) (
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_sda_oe
);
  // Only the data line is an output; the clock always comes from the host
  // Inertial delay drops spikes under 50 ns on both lines
  wire #50     scl = i_scl;
  wire #50     sda = i_sda;
  logic [7:0]  rb;
  logic [7:0]  hold [16];
  logic [7:0]  work [16];
  logic [7:0]  sh;
  logic [15:0] ptr;
  logic        act;
  logic        rd;
  int          bitn;
  int          phase;

  // Missing registers read as zero
  function automatic logic [7:0] rbyte(input logic [15:0] a);
    return (a < 16) ? hold[a[3:0]] : 8'h00;
  endfunction : rbyte

  initial begin
    act = 1'b0;
    rd = 1'b0;
    bitn = 0;
    phase = 0;
    ptr = 16'h0000;
    o_sda_oe = 1'b0;
    foreach (hold[i]) hold[i] = 8'h00;
  end

  // A start anywhere drops a partial byte; the pointer survives it
  always @(negedge sda) if (scl === 1'b1) begin
    act = 1'b1;
    rd = 1'b0;
    bitn = 0;
    phase = 0;
    o_sda_oe <= 1'b0;
  end

  always @(posedge sda) if (scl === 1'b1) begin
    act = 1'b0;
    o_sda_oe <= 1'b0;
  end

  // Sample while the clock is high; works at any bus rate
  always @(posedge scl) if (act) begin
    if (bitn < 8) begin
      sh = {sh[6:0], sda};
      bitn++;
    end else begin
      bitn = 0;
      if (phase == 4) begin
        ptr++;
        if (sda) act = 1'b0;
      end
      if (phase == 5) phase = 4;
    end
  end

  // Drive only while the clock is low
  always @(negedge scl) if (act) begin
    if (bitn == 8) begin
      o_sda_oe <= 1'b0;
      if (!rd) begin
        case (phase)
          0: begin
            if (sh[7:1] == {4'h9, STRAP}) begin
              o_sda_oe <= 1'b1;
              rd = sh[0];
              phase = sh[0] ? 5 : 1;
            end else begin
              act = 1'b0;
            end
          end
          1: begin
            ptr[15:8] = sh;
            phase = 2;
            o_sda_oe <= 1'b1;
          end
          2: begin
            ptr[7:0] = sh;
            phase = 3;
            o_sda_oe <= 1'b1;
          end
          default: begin
            if (ptr < 16) begin
              if (ptr == 16'h0005 && sh[0]) begin
                foreach (work[i]) work[i] = hold[i];
              end
              hold[ptr[3:0]] = (ptr == 16'h0005) ? (sh & 8'hFE) : sh;
            end
            ptr++;
            o_sda_oe <= 1'b1;
          end
        endcase
      end
    end else if (rd) begin
      rb = rbyte(ptr);
      o_sda_oe <= ~rb[7 - bitn];
    end else begin
      o_sda_oe <= 1'b0;
    end
  end
endmodule : i2c_dev_model

/* File: dv/testbench.sv */
// Self-checking bench: host controller against a behavioural device
`timescale 1ns/1ps
module testbench
  import i2c_host_pkg::*;
;
  localparam logic [2:0] DEV_STRAP = 3'h5;
  localparam int         LIMIT     = 99000;

  logic        i_sys_clk;
  logic        i_srst;
  logic        i_req_valid;
  xfer_req_t   req;
  logic        i_fast_mode;
  logic        i_wr_valid;
  logic [7:0]  i_wr_data;
  logic        h_scl_oe;
  logic        h_sda_oe;
  logic        h_scl_out;
  logic        h_sda_out;
  logic        m_sda_oe;
  logic        o_req_ready;
  logic        o_done;
  logic        o_nack;
  logic        o_wr_pop;
  logic        o_rd_valid;
  logic [7:0]  o_rd_data;
  logic [7:0]  mem [16];
  logic [7:0]  wq [$];
  logic [7:0]  exp_rd [$];
  logic        exp_nk [$];
  logic [15:0] seed_d;
  logic [15:0] seed_v;
  int          cyc;
  int          error_cnt;
  int          compares;

  // Open-drain wires with pull-ups; a driven pin shows the host's level
  wire scl_w = ~h_scl_oe | h_scl_out;
  wire sda_w = (~h_sda_oe | h_sda_out) & ~m_sda_oe;

  i2c_host_ctrl u_i2c_host_ctrl (
    .i_sys_clk   (i_sys_clk),
    .i_srst      (i_srst),
    .i_req_valid (i_req_valid),
    .i_req       (req),
    .i_fast_mode (i_fast_mode),
    .i_wr_valid  (i_wr_valid),
    .i_wr_data   (i_wr_data),
    .i_scl_in    (scl_w),
    .i_sda_in    (sda_w),
    .o_scl_out   (h_scl_out),
    .o_scl_oe    (h_scl_oe),
    .o_sda_out   (h_sda_out),
    .o_sda_oe    (h_sda_oe),
    .o_req_ready (o_req_ready),
    .o_done      (o_done),
    .o_nack      (o_nack),
    .o_wr_pop    (o_wr_pop),
    .o_rd_valid  (o_rd_valid),
    .o_rd_data   (o_rd_data)
  );

  i2c_dev_model #(.STRAP(DEV_STRAP)) u_i2c_dev_model (
    .i_scl    (scl_w),
    .i_sda    (sda_w),
    .o_sda_oe (m_sda_oe)
  );

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic check(input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : check

  task automatic summarize();
    if (error_cnt == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  // Notes expectations, then runs one bus transfer to its done pulse
  task automatic xfer(input logic rnw, input logic [15:0] a,
                      input logic [15:0] n, input logic [2:0] st,
                      input logic fast);
    logic        nk;
    logic [7:0]  d;
    logic [15:0] p;
    nk = (st != DEV_STRAP);
    exp_nk.push_back(nk);
    for (int i = 0; i < n; i++) begin
      p = a + 16'(i);
      if (!rnw) begin
        seed_d = lfsr_next(seed_d);
        d = seed_d[7:0];
        wq.push_back(d);
        if (p < 16) mem[p[3:0]] = (p == 16'h0005) ? (d & 8'hFE) : d;
      end else if (!nk) begin
        exp_rd.push_back((p < 16) ? mem[p[3:0]] : 8'h00);
      end
    end
    req.rnw = rnw;
    req.strap = st;
    req.reg_addr = a;
    req.count = n;
    i_fast_mode = fast;
    i_req_valid = 1'b1;
    @(posedge i_sys_clk);
    #1;
    i_req_valid = 1'b0;
    check(16'h0000, {15'h0000, o_req_ready});
    while (o_done !== 1'b1) begin
      @(posedge i_sys_clk);
      #1;
    end
  endtask : xfer

  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  // Write bytes follow pops; valid drops at random to make the host wait
  always @(posedge i_sys_clk) begin
    #1;
    if (o_wr_pop === 1'b1) void'(wq.pop_front());
    seed_v = lfsr_next(seed_v);
    i_wr_valid = (wq.size() > 0) && seed_v[0];
    i_wr_data = (wq.size() > 0) ? wq[0] : 8'h00;
  end

  always @(posedge i_sys_clk) begin
    if (o_rd_valid === 1'b1) begin
      if (exp_rd.size() > 0) begin
        check({8'h00, exp_rd.pop_front()}, {8'h00, o_rd_data});
      end else begin
        check(16'hFFFF, {8'h00, o_rd_data});
      end
    end
    if (o_done === 1'b1 && exp_nk.size() > 0) begin
      check({15'h0000, exp_nk.pop_front()}, {15'h0000, o_nack});
      check(16'h0001, {15'h0000, o_req_ready});
      check(16'h0000, {14'h0000, h_scl_out, h_sda_out});
    end
  end

  // Hang guard, sized for the slow-mode transfer plus the fast ones
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      error_cnt++;
      summarize();
    end
  end

  initial begin
    i_srst = 1'b1;
    i_req_valid = 1'b0;
    req = '0;
    i_fast_mode = 1'b1;
    i_wr_valid = 1'b0;
    i_wr_data = 8'h00;
    seed_d = 16'h7EE1;
    seed_v = 16'h7EE1;
    cyc = 0;
    error_cnt = 0;
    compares = 0;
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (4) @(posedge i_sys_clk);
    #1;
    i_srst = 1'b0;
    repeat (8) @(posedge i_sys_clk);
    #1;
    xfer(1'b0, 16'h0003, 16'h0003, DEV_STRAP, 1'b1);
    xfer(1'b1, 16'h0002, 16'h0004, DEV_STRAP, 1'b1);
    xfer(1'b1, 16'h000F, 16'h0002, DEV_STRAP, 1'b1);
    xfer(1'b1, 16'h0000, 16'h0001, 3'h2, 1'b1);
    xfer(1'b0, 16'h000E, 16'h0000, DEV_STRAP, 1'b0);
    xfer(1'b1, 16'h0004, 16'h0001, DEV_STRAP, 1'b1);
    @(posedge i_sys_clk);
    #1;
    check(16'h0000, 16'(exp_rd.size() + wq.size()));
    summarize();
  end
endmodule : testbench
